// ---- rtl/port_de_pin_control.sv ----
// Purpose: port D (8 pins) and port E (4 pins) direction, latch, pin read and pin muxing
// Assumes: pin inputs are asynchronous and pass two flip-flops before use
// Notes:   pwm and converter internals live elsewhere; steering sync is stored only
//
// The register offsets and the strobed register port were chosen for this implementation.
module port_de_pin_control
    import port_de_pkg::*;
(
    input  wire logic              REF_CLK_IN,
    input  wire logic              SRST_IN,
    input  wire logic [ADDR_W-1:0] REG_ADDR_IN,
    input  wire logic [DATA_W-1:0] REG_WDATA_IN,
    input  wire logic              REG_WR_IN,
    input  wire logic              REG_RD_IN,
    output logic      [DATA_W-1:0] REG_RDATA_OUT,
    input  wire logic              MASTER_CLEAR_ENABLE_IN,
    input  wire logic              PWM_CHANNEL_B_IN,
    input  wire logic              PWM_CHANNEL_C_IN,
    input  wire logic              PWM_CHANNEL_D_IN,
    input  wire logic [7:0]        PORT_D_PIN_IN,
    output logic      [7:0]        PORT_D_PIN_OUT,
    output logic      [7:0]        PORT_D_PIN_OE_OUT,
    input  wire logic [3:0]        PORT_E_PIN_IN,
    output logic      [3:0]        PORT_E_PIN_OUT,
    output logic      [3:0]        PORT_E_PIN_OE_OUT,
    output logic      [2:0]        ANALOG_ENABLE_OUT,
    output logic                   WEAK_PULLUP_OUT,
    output logic                   MASTER_CLEAR_INPUT_OUT,
    output logic      [3:0]        STEER_ENABLE_OUT
);

    reg_req_t   req;
    logic [7:0] pd_meta_q;
    logic [7:0] pd_sync_q;
    logic [3:0] pe_meta_q;
    logic [3:0] pe_sync_q;
    logic [7:0] pd_latch_q;
    logic [3:0] pe_latch_q;
    logic [7:0] pd_dir_q;
    logic [3:0] pe_dir_q;
    logic [7:0] analog_pin_select_q;
    steer_t     steer_q;
    logic [7:0] pd_read;
    logic [3:0] pe_read;
    logic [7:0] rdata_d;
    logic [2:0] pwm_sig;
    logic [2:0] steer_pwm;
    logic [7:0] pd_out_d;
    logic [3:0] pe_out_d;
    logic [7:0] pd_oe_d;
    logic [3:0] pe_oe_d;

    assign req.addr  = REG_ADDR_IN;
    assign req.wdata = REG_WDATA_IN;
    assign req.wr    = REG_WR_IN;
    assign req.rd    = REG_RD_IN;

    assign pwm_sig   = {PWM_CHANNEL_D_IN, PWM_CHANNEL_C_IN, PWM_CHANNEL_B_IN};
    assign steer_pwm = {steer_q.chan_d, steer_q.chan_c, steer_q.chan_b};

    // pins are asynchronous; only the second stage is read by logic
    always_ff @(posedge REF_CLK_IN) begin
        pd_meta_q <= PORT_D_PIN_IN;
        pd_sync_q <= pd_meta_q;
        pe_meta_q <= PORT_E_PIN_IN;
        pe_sync_q <= pe_meta_q;
    end

    // pin level as software sees it; no analog select for port D on this part
    always_comb begin
        pd_read = pd_sync_q;
        pe_read = pe_sync_q;
        for (int i = 0; i < 3; i++) begin
            if (analog_pin_select_q[AN_PE_LO + i]) begin
                pe_read[i] = 1'b0;
            end
        end
        if (MASTER_CLEAR_ENABLE_IN) begin
            pe_read[PE_PIN3] = 1'b0;
        end
    end

    // latches have no reset: only the direction, analog select and steering registers take defaults
    // no read-modify-write: port D stores the write data whole; port E stores
    // write data bits 2:0 and takes bit 3 from the pin 3 read
    always_ff @(posedge REF_CLK_IN) begin
        if (req.wr && req.addr == OFS_PORT_D_DATA) begin
            pd_latch_q <= req.wdata;
        end
        if (req.wr && req.addr == OFS_PORT_E_DATA) begin
            // pin 3 bit is read-only and never reaches a driver
            pe_latch_q <= {pe_read[PE_PIN3], req.wdata[2:0]};
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            pd_dir_q <= RST_PORT_D_DIR;
        end else if (req.wr && req.addr == OFS_PORT_D_DIR) begin
            pd_dir_q <= req.wdata;
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            pe_dir_q <= RST_PORT_E_DIR;
        end else if (req.wr && req.addr == OFS_PORT_E_DIR) begin
            pe_dir_q <= {1'b1, req.wdata[2:0]};
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            analog_pin_select_q <= RST_ANALOG_SELECT;
        end else if (req.wr && req.addr == OFS_ANALOG_SELECT) begin
            analog_pin_select_q <= req.wdata;
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            steer_q <= steer_t'(RST_PWM_STEERING);
        end else if (req.wr && req.addr == OFS_PWM_STEERING) begin
            steer_q <= steer_t'(req.wdata[4:0]);
        end
    end

    always_comb begin
        rdata_d = READ_UNMAPPED;
        unique case (req.addr)
            OFS_PORT_D_DATA:   rdata_d = pd_read;
            OFS_PORT_D_DIR:    rdata_d = pd_dir_q;
            OFS_PORT_E_DATA:   rdata_d = {4'h0, pe_read};
            OFS_PORT_E_DIR:    rdata_d = {4'h0, pe_dir_q};
            OFS_ANALOG_SELECT: rdata_d = analog_pin_select_q;
            OFS_PWM_STEERING:  rdata_d = {3'h0, steer_q};
            default:           rdata_d = READ_UNMAPPED;
        endcase
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            REG_RDATA_OUT <= READ_UNMAPPED;
        end else if (req.rd) begin
            REG_RDATA_OUT <= rdata_d;
        end else begin
            REG_RDATA_OUT <= READ_UNMAPPED;
        end
    end

    // driver selection per pin
    always_comb begin
        pd_out_d = pd_latch_q;
        pd_oe_d  = ~pd_dir_q;
        for (int i = 0; i < 3; i++) begin
            if (steer_pwm[i]) begin
                pd_out_d[PD_PWM_LO + i] = pwm_sig[i];
            end
        end
        // analog select never removes the driver: direction alone decides
        pe_out_d = {1'b0, pe_latch_q[2:0]};
        pe_oe_d  = {1'b0, ~pe_dir_q[2:0]};
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            PORT_D_PIN_OUT    <= 8'h00;
            PORT_D_PIN_OE_OUT <= 8'h00;
            PORT_E_PIN_OUT    <= 4'h0;
            PORT_E_PIN_OE_OUT <= 4'h0;
        end else begin
            PORT_D_PIN_OUT    <= pd_out_d;
            PORT_D_PIN_OE_OUT <= pd_oe_d;
            PORT_E_PIN_OUT    <= pe_out_d;
            PORT_E_PIN_OE_OUT <= pe_oe_d;
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            ANALOG_ENABLE_OUT      <= 3'h7;
            WEAK_PULLUP_OUT        <= 1'b0;
            MASTER_CLEAR_INPUT_OUT <= 1'b0;
            STEER_ENABLE_OUT       <= 4'h1;
        end else begin
            ANALOG_ENABLE_OUT      <= analog_pin_select_q[AN_PE_LO +: 3];
            WEAK_PULLUP_OUT        <= MASTER_CLEAR_ENABLE_IN;
            // reset request is active low on the pin, passed on synchronised
            MASTER_CLEAR_INPUT_OUT <= MASTER_CLEAR_ENABLE_IN & ~pe_sync_q[PE_PIN3];
            STEER_ENABLE_OUT       <= {steer_q.chan_d, steer_q.chan_c,
                                       steer_q.chan_b, steer_q.chan_a};
        end
    end

endmodule : port_de_pin_control

// ---- rtl/port_de_pkg.sv ----
// Purpose: constants and types for the port D / port E pin control block
// Assumes: 8-bit register port, read data one cycle after the read strobe
// Notes:   register offsets are word indices on the plain register port
// Operation
// - Port E has three bidirectional pins and one input pin, each with its own direction bit.
// - A port E direction bit of one turns the driver off; pin is input.
// - A port E direction bit of zero drives the pin from its latch.
// - Port E pin 3 is input only; direction reads one, data read-only.
// - Data reads return pin levels; data writes update only the output latch.
// - Port writes are read-modify-write: pins sampled, merged, whole latch stored; the code stores the write data, port E bit 3 from the pin read.
// - With master clear enabled, port E pin 3 reads zero.
// - Port E direction bits still control drivers of analog-selected pins.
// - Pins selected as analog inputs read back zero.
// - Port E data and direction bits 7 to 4 read zero.
// - Port E data bits read one above input-high, zero below input-low.
// - Reset sets direction and analog select to ones; latches unchanged.
// - Port D pins 0 to 4 are plain general purpose I/O only.
// - Port D pins 5 to 7 may carry PWM channels B, C and D.
// - Port E pins 0 to 2 may serve as analog converter inputs.
// - Port E pin 3 is an input or master clear with weak pull-up.
// - Port D has eight pins; direction one is input, zero is output.
package port_de_pkg;

    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 8;

    localparam logic [ADDR_W-1:0] OFS_PORT_D_DATA   = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_PORT_D_DIR    = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_PORT_E_DATA   = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_PORT_E_DIR    = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_ANALOG_SELECT = 3'h4;
    localparam logic [ADDR_W-1:0] OFS_PWM_STEERING  = 3'h5;

    localparam logic [7:0] RST_PORT_D_DIR    = 8'hFF;
    localparam logic [3:0] RST_PORT_E_DIR    = 4'hF;
    localparam logic [7:0] RST_ANALOG_SELECT = 8'hFF;
    localparam logic [4:0] RST_PWM_STEERING  = 5'h01;

    localparam int unsigned PE_PIN3       = 3;
    localparam int unsigned PD_PWM_LO     = 5;
    localparam int unsigned AN_PE_LO      = 5;
    localparam logic [7:0]  READ_UNMAPPED = 8'h00;

    // steering register fields, bit 4 downward
    typedef struct packed {
        logic sync_select;
        logic chan_d;
        logic chan_c;
        logic chan_b;
        logic chan_a;
    } steer_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_t;

endpackage : port_de_pkg

// ---- verif/port_de_monitor.sv ----
// Purpose: port checks for the port D/E pin control block
// Assumes: pin outputs follow a register write by two edges
// Notes: bound to every instance of the block
module port_de_monitor
    import port_de_pkg::*;
(
    input wire logic       REF_CLK_IN,
    input wire logic       SRST_IN,
    input wire logic [2:0] REG_ADDR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    input wire logic       REG_WR_IN,
    input wire logic       REG_RD_IN,
    input wire logic [7:0] REG_RDATA_OUT,
    input wire logic [7:0] PORT_D_PIN_OE_OUT,
    input wire logic [3:0] PORT_E_PIN_OUT,
    input wire logic [3:0] PORT_E_PIN_OE_OUT
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (SRST_IN);
    e3_input_only_a: assert property (!PORT_E_PIN_OE_OUT[3])
        else $error("E3 driven");
    rdata_idle_a: assert property (!$past(REG_RD_IN) |-> REG_RDATA_OUT == 8'h00)
        else $error("stray read data");
    e_dir_read_a: assert property (REG_RD_IN && REG_ADDR_IN == OFS_PORT_E_DIR
        |=> REG_RDATA_OUT[7:3] == 5'h01) else $error("E dir readback");
    e_data_read_a: assert property (REG_RD_IN && REG_ADDR_IN == OFS_PORT_E_DATA
        |=> REG_RDATA_OUT[7:4] == 4'h0) else $error("E data high bits");
    steer_read_a: assert property (REG_RD_IN && REG_ADDR_IN == OFS_PWM_STEERING
        |=> REG_RDATA_OUT[7:5] == 3'h0) else $error("steering high bits");
    e_dir_oe_a: assert property (REG_WR_IN && REG_ADDR_IN == OFS_PORT_E_DIR
        |-> ##2 PORT_E_PIN_OE_OUT[2:0] == ~$past(REG_WDATA_IN[2:0], 2)) else $error("E driver");
    d_dir_oe_a: assert property (REG_WR_IN && REG_ADDR_IN == OFS_PORT_D_DIR
        |-> ##2 PORT_D_PIN_OE_OUT == ~$past(REG_WDATA_IN, 2)) else $error("D driver");
    e_latch_a: assert property (REG_WR_IN && REG_ADDR_IN == OFS_PORT_E_DATA |-> ##2
        (PORT_E_PIN_OE_OUT[2:0] != 3'h7 || PORT_E_PIN_OUT[2:0] == $past(REG_WDATA_IN[2:0], 2)))
        else $error("E latch");
endmodule : port_de_monitor
bind port_de_pin_control port_de_monitor u_mon (.*);

// ---- verif/pin_world.sv ----
// Purpose: pins and outside drivers around port D and port E
// Assumes: outside drive shows only where the block's driver is off
// Notes: bits 7:0 are port D, bits 11:8 port E
module pin_world (
    input  wire logic [11:0] out_in,
    input  wire logic [11:0] oe_in,
    input  wire logic [11:0] ext_in,
    output logic      [11:0] pin_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // a released pin shows the outside level, never the last driven value
    assign pin_out = (oe_in & out_in) | (~oe_in & ext_in);
endmodule : pin_world

// ---- verif/port_de_pin_control_tb.sv ----
// Purpose: self-checking bench for the port D/E pin control block
// Assumes: pins resolved by pin_world, pwm levels driven here
// Notes: every access waits four edges so pin changes have landed
module port_de_pin_control_tb
    import port_de_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, mce = 1'b0;
    logic [2:0]  addr = 3'h0, pwm = 3'h0, an;
    logic [7:0]  wdata = 8'h00, rdata, d_out, d_oe;
    logic [3:0]  e_out, e_oe, steer;
    logic [11:0] ext = 12'h000, pin;
    logic        wpu, mci;
    int          n_fail = 0, total_checks = 0;
    initial forever #20 clk = ~clk;
    port_de_pin_control DUT (.REF_CLK_IN(clk), .SRST_IN(srst), .REG_ADDR_IN(addr),
        .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
        .MASTER_CLEAR_ENABLE_IN(mce), .PWM_CHANNEL_B_IN(pwm[0]), .PWM_CHANNEL_C_IN(pwm[1]),
        .PWM_CHANNEL_D_IN(pwm[2]), .PORT_D_PIN_IN(pin[7:0]), .PORT_D_PIN_OUT(d_out),
        .PORT_D_PIN_OE_OUT(d_oe), .PORT_E_PIN_IN(pin[11:8]), .PORT_E_PIN_OUT(e_out),
        .PORT_E_PIN_OE_OUT(e_oe), .ANALOG_ENABLE_OUT(an), .WEAK_PULLUP_OUT(wpu),
        .MASTER_CLEAR_INPUT_OUT(mci), .STEER_ENABLE_OUT(steer));
    pin_world u_pins (.out_in({e_out, d_out}), .oe_in({e_oe, d_oe}), .ext_in(ext), .pin_out(pin));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask : chk
    // w=1 writes d, w=0 reads and compares against d
    task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
        repeat (4) @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        if (!w) #1 chk(rdata, d);
    endtask : acc
    task automatic end_sim;
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        acc(0, OFS_PORT_D_DIR, 8'hFF);
        acc(0, OFS_PORT_E_DIR, 8'h0F);
        acc(0, OFS_ANALOG_SELECT, 8'hFF);
        chk({5'h00, an}, 8'h07);
        acc(0, OFS_PWM_STEERING, 8'h01);
        acc(0, 3'h6, READ_UNMAPPED);
        acc(1, OFS_ANALOG_SELECT, 8'h00);
        acc(1, OFS_PORT_E_DIR, 8'hF0);
        acc(0, OFS_PORT_E_DIR, 8'h08);
        acc(1, OFS_PORT_E_DATA, 8'hFF);
        ext <= 12'h800;
        acc(0, OFS_PORT_E_DATA, 8'h0F);
        acc(1, OFS_PORT_E_DATA, 8'h05);
        mce <= 1'b1;
        acc(0, OFS_PORT_E_DATA, 8'h05);
        chk({7'h00, wpu}, 8'h01);
        chk({7'h00, mci}, 8'h00);
        acc(1, OFS_PORT_E_DIR, 8'h0F);
        mce <= 1'b0;
        ext <= 12'hF00;
        acc(0, OFS_PORT_E_DATA, 8'h0F);
        chk({7'h00, wpu}, 8'h00);
        acc(1, OFS_ANALOG_SELECT, 8'hA0);
        acc(0, OFS_PORT_E_DATA, 8'h0A);
        chk({5'h00, an}, 8'h05);
        acc(1, OFS_PORT_D_DIR, 8'h00);
        acc(1, OFS_PORT_D_DATA, 8'hA5);
        ext <= 12'h05A;
        acc(0, OFS_PORT_D_DATA, 8'hA5);
        acc(1, OFS_PWM_STEERING, 8'hFE);
        pwm <= 3'h2;
        acc(0, OFS_PWM_STEERING, 8'h1E);
        chk({4'h0, steer}, 8'h0E);
        acc(0, OFS_PORT_D_DATA, 8'h45);
        acc(1, OFS_PORT_D_DIR, 8'hFF);
        ext <= 12'h03C;
        acc(0, OFS_PORT_D_DATA, 8'h3C);
        acc(1, OFS_PORT_D_DATA, 8'h96);
        acc(1, OFS_PWM_STEERING, 8'h00);
        acc(1, OFS_PORT_D_DIR, 8'h00);
        acc(0, OFS_PORT_D_DATA, 8'h96);
        end_sim();
    end
endmodule : port_de_pin_control_tb
